// [hw/rom_loader_consts.svh]
`ifndef ROM_LOADER_CONSTS_SVH
`define ROM_LOADER_CONSTS_SVH
`define ROM_DEV_ADDR_RD   8'hA1
`define ROM_IMAGE_BYTES   57
`define ROM_CLK_DIV       384
`define ROM_QUARTER_DIV   96
`define OFS_VENDOR_ID     0
`define OFS_PRODUCT_ID    2
`define OFS_PRODUCT_STR   4
`define OFS_VENDOR_STR    20
`define OFS_POWER_ATTR    52
`define OFS_MAX_POWER     53
`define OFS_AUX_USAGE     54
`define PRODUCT_STR_LEN   16
`define VENDOR_STR_LEN    32
`endif

// [hw/rom_loader_pkg.sv]
package rom_loader_pkg;
   typedef enum {ST_IDLE, ST_START, ST_ADDR, ST_AACK, ST_DATA, ST_DACK, ST_STOP, ST_DONE,
                 ST_FAIL} loader_state_t;
   typedef struct packed {
      logic        loaded;
      logic [15:0] vendor_id;
      logic [15:0] product_id;
      logic [7:0]  power_attr;
      logic [7:0]  max_power;
      logic [23:0] aux_usage;
   } descriptor_t;
   typedef struct packed {
      logic scl_oe;
      logic sda_oe;
   } rom_pins_t;
endpackage

// [hw/bit_sampler.sv]
`timescale 1ns/1ns
`default_nettype none
module bit_sampler (
   input  wire logic i_clk,
   input  wire logic i_rst_b,
   input  wire logic i_pin,
   output logic      o_level
);
   import rom_loader_pkg::*;
   typedef struct packed {
      logic meta;
      logic sync;
   } sync_t;
   sync_t s_r;
   sync_t s_nxt;
   always_comb begin
      s_nxt.meta = i_pin;
      s_nxt.sync = s_r.meta;
   end
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         s_r <= '{meta: 1'b1, sync: 1'b1};
      end else begin
         s_r <= s_nxt;
      end
   end
   assign o_level = s_r.sync;
endmodule
`default_nettype wire

// [hw/descriptor_rom_loader.sv]
`timescale 1ns/1ns
`include "rom_loader_consts.svh"
`default_nettype none
module descriptor_rom_loader #(
   parameter int CLK_DIV = `ROM_CLK_DIV
) (
   input  wire logic                   i_clk,
   input  wire logic                   i_rst_b,
   input  wire logic                   i_rom_serial_data_in,
   output logic                        o_rom_serial_data_out,
   output logic                        o_rom_serial_data_oe,
   output logic                        o_rom_serial_clock_out,
   output logic                        o_rom_serial_clock_oe,
   input  wire logic                   i_usb_req,
   output logic                        o_usb_nack,
   input  wire logic [5:0]             i_str_index,
   output logic [15:0]                 o_str_unit,
   output rom_loader_pkg::descriptor_t o_desc
);
   import rom_loader_pkg::*;
   localparam int QDIV = CLK_DIV / 4;
   // the clock is held low for half a bit; the first 8 cycles are counted by the repetition
   localparam int LOW_END = CLK_DIV / 2 - 7;
   typedef struct packed {
      loader_state_t st;
      logic [8:0]    div;
      logic [1:0]    phase;
      logic [2:0]    bitn;
      logic [5:0]    byten;
      logic [7:0]    shreg;
      logic          scl_low;
      logic          sda_low;
      logic          nack;
      logic          usb_nack;
      logic [15:0]   unit;
      descriptor_t   desc;
      logic [47:0][7:0] str_mem;
   } state_t;
   state_t s_r;
   state_t s_nxt;
   logic   sda_in;
   logic   tick;

   bit_sampler u_sda_sync (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .i_pin   (i_rom_serial_data_in),
      .o_level (sda_in)
   );

   function automatic logic [7:0] bit_rev(input logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         bit_rev[i] = b[7 - i];
      end
   endfunction

   assign tick = (s_r.div == 9'(QDIV - 1));

   always_comb begin
      logic [7:0] v;
      logic [5:0] n;
      v = 8'h00;
      n = 6'h00;
      s_nxt = s_r;
      s_nxt.div = tick ? 9'h000 : s_r.div + 9'h001;
      if (tick) begin
         s_nxt.phase = s_r.phase + 2'h1;
         case (s_r.st)
            ST_IDLE: begin
               // one load per reset; the bus idles one full bit time first
               if (s_r.phase == 2'h3) begin
                  s_nxt.st = ST_START;
               end
            end
            ST_START: begin
               if (s_r.phase == 2'h1) begin
                  s_nxt.sda_low = 1'b1;
               end
               if (s_r.phase == 2'h3) begin
                  s_nxt.scl_low = 1'b1;
                  s_nxt.st = ST_ADDR;
                  s_nxt.bitn = 3'h7;
                  s_nxt.shreg = `ROM_DEV_ADDR_RD;
               end
            end
            ST_ADDR, ST_DACK: begin
               if (s_r.phase == 2'h0) begin
                  s_nxt.sda_low = (s_r.st == ST_ADDR) ? ~s_r.shreg[s_r.bitn]
                                : (s_r.byten != 6'(`ROM_IMAGE_BYTES));
               end
               if (s_r.phase == 2'h1) begin
                  s_nxt.scl_low = 1'b0;
               end
               if (s_r.phase == 2'h3) begin
                  s_nxt.scl_low = 1'b1;
                  if (s_r.st == ST_DACK) begin
                     s_nxt.st = (s_r.byten == 6'(`ROM_IMAGE_BYTES)) ? ST_STOP : ST_DATA;
                     s_nxt.bitn = 3'h7;
                  end else if (s_r.bitn == 3'h0) begin
                     s_nxt.st = ST_AACK;
                  end else begin
                     s_nxt.bitn = s_r.bitn - 3'h1;
                  end
               end
            end
            ST_AACK, ST_DATA: begin
               if (s_r.phase == 2'h0) begin
                  s_nxt.sda_low = 1'b0;
               end
               if (s_r.phase == 2'h1) begin
                  s_nxt.scl_low = 1'b0;
               end
               if (s_r.phase == 2'h2) begin
                  s_nxt.shreg = {s_r.shreg[6:0], sda_in};
               end
               if (s_r.phase == 2'h3) begin
                  s_nxt.scl_low = 1'b1;
                  if (s_r.st == ST_AACK) begin
                     // no ack from the rom: stop; the descriptor fields keep their all-zero reset values, only loaded gets set
                     s_nxt.st = s_r.shreg[0] ? ST_STOP : ST_DATA;
                     s_nxt.nack = s_r.shreg[0] ? 1'b1 : s_r.nack;
                     s_nxt.bitn = 3'h7;
                  end else if (s_r.bitn == 3'h0) begin
                     s_nxt.st = ST_DACK;
                     s_nxt.byten = s_r.byten + 6'h01;
                  end else begin
                     s_nxt.bitn = s_r.bitn - 3'h1;
                  end
               end
            end
            ST_STOP: begin
               if (s_r.phase == 2'h0) begin
                  s_nxt.sda_low = 1'b1;
               end
               if (s_r.phase == 2'h1) begin
                  s_nxt.scl_low = 1'b0;
               end
               if (s_r.phase == 2'h3) begin
                  s_nxt.sda_low = 1'b0;
                  s_nxt.st = s_r.nack ? ST_FAIL : ST_DONE;
                  s_nxt.desc.loaded = 1'b1;
               end
            end
            ST_DONE, ST_FAIL: begin
               s_nxt.phase = s_r.phase;
            end
            default: begin
               s_nxt.st = ST_IDLE;
            end
         endcase
      end
      // latch the byte after its last bit; the shift register holds it reversed
      if (tick && s_r.st == ST_DATA && s_r.phase == 2'h3 && s_r.bitn == 3'h0) begin
         v = bit_rev(s_r.shreg);
         n = s_r.byten;
         case (n)
            6'(`OFS_VENDOR_ID):      s_nxt.desc.vendor_id[7:0]   = v;
            6'(`OFS_VENDOR_ID + 1):  s_nxt.desc.vendor_id[15:8]  = v;
            6'(`OFS_PRODUCT_ID):     s_nxt.desc.product_id[7:0]  = v;
            6'(`OFS_PRODUCT_ID + 1): s_nxt.desc.product_id[15:8] = v;
            6'(`OFS_POWER_ATTR):     s_nxt.desc.power_attr       = v;
            6'(`OFS_MAX_POWER):      s_nxt.desc.max_power        = v;
            6'(`OFS_AUX_USAGE):      s_nxt.desc.aux_usage[7:0]   = v;
            6'(`OFS_AUX_USAGE + 1):  s_nxt.desc.aux_usage[15:8]  = v;
            6'(`OFS_AUX_USAGE + 2):  s_nxt.desc.aux_usage[23:16] = v;
            default: begin
               if (n >= 6'(`OFS_PRODUCT_STR) && n < 6'(`OFS_POWER_ATTR)) begin
                  s_nxt.str_mem[n - 6'(`OFS_PRODUCT_STR)] = v;
               end
            end
         endcase
      end
      // index 0..15 product string, 16..47 vendor string
      s_nxt.unit = {8'h00, (i_str_index < 6'h30) ? s_r.str_mem[i_str_index] : 8'h00};
      // registered so the nack pin comes straight from a flop, in step with loaded
      s_nxt.usb_nack = ~s_nxt.desc.loaded;
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         s_r.st      <= ST_IDLE;
         s_r.div     <= 9'h000;
         s_r.phase   <= 2'h0;
         s_r.bitn    <= 3'h7;
         s_r.byten   <= 6'h00;
         s_r.shreg   <= 8'h00;
         s_r.scl_low <= 1'b0;
         s_r.sda_low <= 1'b0;
         s_r.nack    <= 1'b0;
         s_r.usb_nack <= 1'b1;
         s_r.unit    <= 16'h0000;
         s_r.desc    <= '0;
         for (int i = 0; i < 48; i++) begin
            s_r.str_mem[i] <= 8'h00;
         end
      end else begin
         s_r <= s_nxt;
      end
   end

   // open drain: only ever pull low, release for high
   assign o_rom_serial_data_out  = 1'b0;
   assign o_rom_serial_data_oe   = s_r.sda_low;
   assign o_rom_serial_clock_out = 1'b0;
   assign o_rom_serial_clock_oe  = s_r.scl_low;
   assign o_usb_nack             = s_r.usb_nack;
   assign o_str_unit             = s_r.unit;
   assign o_desc                 = s_r.desc;

   property p_nack_until_loaded;
      @(posedge i_clk) disable iff (!i_rst_b)
      (s_r.st != ST_DONE && s_r.st != ST_FAIL) |-> o_usb_nack;
   endproperty
   a_nack_until_loaded: assert property (p_nack_until_loaded) else $error("nack dropped early");

   property p_bus_rate;
      @(posedge i_clk) disable iff (!i_rst_b)
      $rose(s_r.scl_low) && s_r.st == ST_ADDR |-> s_r.scl_low [*8] ##LOW_END !s_r.scl_low;
   endproperty
   a_bus_rate: assert property (p_bus_rate) else $error("rom clock low time wrong");

   property p_start_cond;
      @(posedge i_clk) disable iff (!i_rst_b)
      $rose(s_r.sda_low) && !s_r.scl_low && s_r.st == ST_START |-> ##1 s_r.sda_low;
   endproperty
   a_start_cond: assert property (p_start_cond) else $error("start condition broken");

   property p_byte_count;
      @(posedge i_clk) disable iff (!i_rst_b)
      s_r.byten <= 6'(`ROM_IMAGE_BYTES);
   endproperty
   a_byte_count: assert property (p_byte_count) else $error("read too many bytes");

   property p_last_nack;
      @(posedge i_clk) disable iff (!i_rst_b)
      s_r.st == ST_DACK && s_r.byten == 6'(`ROM_IMAGE_BYTES) && s_r.phase == 2'h2
         |-> !o_rom_serial_data_oe;
   endproperty
   a_last_nack: assert property (p_last_nack) else $error("last byte not nacked");

   property p_data_ack;
      @(posedge i_clk) disable iff (!i_rst_b)
      s_r.st == ST_DACK && s_r.byten != 6'(`ROM_IMAGE_BYTES) && s_r.phase == 2'h2
         |-> o_rom_serial_data_oe;
   endproperty
   a_data_ack: assert property (p_data_ack) else $error("data byte not acked");

   property p_once;
      @(posedge i_clk) disable iff (!i_rst_b)
      s_r.st == ST_DONE |=> s_r.st == ST_DONE;
   endproperty
   a_once: assert property (p_once) else $error("load restarted");

   property p_sda_stable;
      @(posedge i_clk) disable iff (!i_rst_b)
      (s_r.st == ST_DATA || s_r.st == ST_ADDR) && !s_r.scl_low && !$past(s_r.scl_low)
         |-> $stable(o_rom_serial_data_oe);
   endproperty
   a_sda_stable: assert property (p_sda_stable) else $error("data moved with clock high");
endmodule
`default_nettype wire

// [testbench/rom_model.sv]
`timescale 1ns/1ns
`default_nettype none
module rom_model (
   input  wire logic i_scl,
   input  wire logic i_sda,
   input  wire logic i_ack_addr,
   output logic      o_drv_low
);
   logic [7:0] mem [64];
   logic [7:0] addr_seen;
   logic       last_nack;
   logic       mack;
   int         nbytes;
   int         starts;
   int         k;
   initial begin
      o_drv_low = 1'b0;
      starts = 0;
      forever begin
         @(negedge i_sda iff i_scl === 1'b1);
         starts++;
         for (k = 0; k < 8; k++) begin
            @(posedge i_scl);
            addr_seen = {addr_seen[6:0], i_sda};
         end
         @(negedge i_scl);
         #10 o_drv_low = i_ack_addr;
         @(negedge i_scl);
         #10 o_drv_low = 1'b0;
         nbytes = 0;
         mack = !i_ack_addr;
         while (!mack) begin
            // stored msb goes first, which is the value's lsb
            for (k = 7; k >= 0; k--) begin
               o_drv_low = ~mem[nbytes][k];
               @(negedge i_scl);
               #10;
            end
            // released for the master's ack; pull-up gives high
            o_drv_low = 1'b0;
            @(posedge i_scl);
            mack = i_sda;
            nbytes++;
            @(negedge i_scl);
            #10;
         end
         last_nack = mack;
         @(posedge i_sda iff i_scl === 1'b1);
      end
   end
endmodule
`default_nettype wire

// [testbench/descriptor_rom_loader_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module descriptor_rom_loader_tb_top;
   import rom_loader_pkg::*;
   localparam int DIV = 16;
   logic        clk, rst_b, req, ack_addr, drv, scl, sda;
   logic        d_out, d_oe, c_out, c_oe;
   logic        nack;
   logic [5:0]  idx;
   logic [15:0] unit;
   descriptor_t desc;
   int          num_errors = 0;
   int          n_checks = 0;
   // open-drain lines with pull-ups
   assign scl = !c_oe;
   assign sda = !(d_oe || drv);
   descriptor_rom_loader #(.CLK_DIV(DIV)) i_descriptor_rom_loader (
      .i_clk(clk), .i_rst_b(rst_b), .i_rom_serial_data_in(sda),
      .o_rom_serial_data_out(d_out), .o_rom_serial_data_oe(d_oe),
      .o_rom_serial_clock_out(c_out), .o_rom_serial_clock_oe(c_oe),
      .i_usb_req(req), .o_usb_nack(nack), .i_str_index(idx),
      .o_str_unit(unit), .o_desc(desc));
   rom_model i_rom_model (.i_scl(scl), .i_sda(sda), .i_ack_addr(ack_addr), .o_drv_low(drv));
   always #5 clk = ~clk;
   function automatic logic [7:0] val(int i);
      if (i == 52) return 8'h80;
      if (i == 53) return 8'h7D;
      return 8'(i * 37 + 19);
   endfunction
   function automatic logic [7:0] rev8(logic [7:0] b);
      logic [7:0] r;
      r = {<<{b}};
      return r;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks=%0d errors=%0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic do_reset();
      @(posedge clk);
      #1 rst_b = 1'b0;
      repeat (2) @(posedge clk);
      #1 rst_b = 1'b1;
   endtask
   task automatic wait_loaded();
      int n;
      n = 0;
      while (desc.loaded !== 1'b1 && n < 700 * DIV) begin
         @(posedge clk);
         n++;
      end
      #1 chk(32'(desc.loaded), 32'h1);
   endtask
   task automatic t_load();
      time t0;
      ack_addr = 1'b1;
      do_reset();
      repeat (3 * DIV) @(posedge clk);
      #1 req = 1'b1;
      @(posedge clk);
      #1 req = 1'b0;
      chk(32'(nack), 32'h1);
      chk(32'(desc.loaded), 32'h0);
      chk(32'({d_out, c_out}), 32'h0);
      @(negedge c_oe);
      t0 = $time;
      @(negedge c_oe);
      chk(32'($time - t0), 32'(DIV * 10));
      wait_loaded();
      chk(32'(nack), 32'h0);
      chk(32'(desc.vendor_id), 32'({val(1), val(0)}));
      chk(32'(desc.product_id), 32'({val(3), val(2)}));
      chk(32'(desc.power_attr), 32'(val(52)));
      chk(32'(desc.max_power), 32'(val(53)));
      chk(32'(desc.aux_usage), 32'({val(56), val(55), val(54)}));
      chk(32'(i_rom_model.addr_seen), 32'hA1);
      chk(32'(i_rom_model.nbytes), 32'd57);
      chk(32'(i_rom_model.last_nack), 32'h1);
      repeat (4 * DIV) @(posedge clk);
      chk(32'(i_rom_model.starts), 32'h1);
      $display("t_load done");
   endtask
   task automatic t_strings();
      for (int i = 0; i < 48; i++) begin
         @(posedge clk);
         #1 idx = 6'(i);
         @(posedge clk);
         #1 chk(32'(unit), 32'({8'h00, val(4 + i)}));
      end
      $display("t_strings done");
   endtask
   task automatic t_refused();
      ack_addr = 1'b0;
      do_reset();
      wait_loaded();
      chk(32'(nack), 32'h0);
      chk(desc.vendor_id + desc.product_id + desc.aux_usage, 32'h0);
      chk(32'(i_rom_model.nbytes), 32'h0);
      chk(32'(i_rom_model.starts), 32'h2);
      $display("t_refused done");
   endtask
   initial begin
      #(2000 * DIV * 10);
      num_errors++;
      $display("[FAIL] t=%0t watchdog got=0 exp=1", $time);
      report_and_stop();
   end
   initial begin
      clk = 1'b0;
      rst_b = 1'b0;
      req = 1'b0;
      idx = 6'h00;
      ack_addr = 1'b1;
      // the rom holds every byte bit-reversed
      for (int i = 0; i < 64; i++) begin
         i_rom_model.mem[i] = (i < 57) ? rev8(val(i)) : 8'hFF;
      end
      t_load();
      t_strings();
      t_refused();
      report_and_stop();
   end
endmodule
`default_nettype wire
